// ---- fault_alert_pkg.sv ----
// package for the second fault-alert register bank
// assumes a single 25 MHz clock domain and a plain strobe register port
package fault_alert_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [3:0] fault_alerts_two_off = 4'h6;
   localparam logic [3:0] irq_status_off = 4'h9;
   localparam logic [3:0] irq_mask_off = 4'hA;
   localparam logic [3:0] monitor_ctrl_off = 4'hB;
   localparam logic [15:0] fault_alerts_two_rst = 16'h0000;
   localparam logic [15:0] mask_rst = 16'h0000;
   localparam logic [15:0] ctrl_rst = 16'h0000;
   // ****************************************
   // field positions
   // ****************************************
   localparam int user_test_pos = 15;
   localparam int supply_mux_pos = 14;
   localparam int aux_sum_pos = 13;
   localparam int overtemp_pos = 12;
   localparam int scan_to_pos = 11;
   localparam int zero_scale_pos = 3;
   localparam int full_scale_pos = 2;
   localparam int comp_high_pos = 1;
   localparam int comp_low_pos = 0;
   localparam logic [15:0] defined_mask = 16'hF80F;
   localparam logic [15:0] w0c_mask = 16'h500F;
   // monitor_ctrl fields
   localparam int flex_pack_pos = 0;
   localparam int selftest_en_pos = 1;
   localparam int comp_acc_en_pos = 2;
   localparam int scan_to_dis_pos = 3;
   localparam int scan_cfg_lsb = 4;
   localparam logic [2:0] scan_cfg_a = 3'h1;
   localparam logic [2:0] scan_cfg_b = 3'h2;
   localparam logic [1:0] balance_thermal_code = 2'h3;
   localparam logic [1:0] balance_idle_code = 2'h0;

   typedef struct packed {
      logic supply_mux;
      logic overtemp;
      logic zero_scale;
      logic full_scale;
      logic comp_high;
      logic comp_low;
   } fault_events_s;

   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;
endpackage

// ---- fault_alert_register_two.sv ----
// second fault-alert register with interrupt status and mask
// assumes fault sources and strobes are synchronous to clk
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
module fault_alert_register_two (
   input wire logic clk,
   input wire logic sys_rst,
   input wire fault_alert_pkg::reg_req_s req,
   output logic [15:0] rdata,
   input wire fault_alert_pkg::fault_events_s events,
   input wire logic supply_mux_fault_now,
   input wire logic reset_alert,
   input wire logic [5:0] aux_protect_flags,
   input wire logic [5:0] aux_analog_input,
   input wire logic scan_timeout_flag,
   input wire logic balance_active,
   output logic [15:0] fault_alerts_two,
   output logic user_test_alert,
   output logic balance_stop,
   output logic balance_thermal_stop,
   output logic [1:0] balance_activity_state,
   output logic irq
);
   import fault_alert_pkg::*;

   logic [15:0] fa_reg;
   logic [15:0] fa_next;
   logic [15:0] irq_status_reg;
   logic [15:0] irq_mask_reg;
   logic [15:0] ctrl_reg;
   logic [15:0] set_vec;
   logic [15:0] prev_reg;
   logic [2:0] scan_cfg;
   logic mux_detect;
   logic comp_ok;
   logic wr_fa;

   // ****************************************
   // qualification of fault sources
   // ****************************************
   assign scan_cfg = ctrl_reg[scan_cfg_lsb +: 3];
   assign mux_detect = ctrl_reg[flex_pack_pos] && !reset_alert;
   assign comp_ok = ctrl_reg[comp_acc_en_pos] &&
      (scan_cfg == scan_cfg_a || scan_cfg == scan_cfg_b);
   assign wr_fa = req.wr && (req.addr == fault_alerts_two_off);

   always_comb begin
      set_vec = 16'h0000;
      set_vec[supply_mux_pos] = mux_detect && events.supply_mux;
      set_vec[overtemp_pos] = events.overtemp;
      set_vec[zero_scale_pos] = ctrl_reg[selftest_en_pos] && events.zero_scale;
      set_vec[full_scale_pos] = ctrl_reg[selftest_en_pos] && events.full_scale;
      set_vec[comp_high_pos] = comp_ok && events.comp_high;
      set_vec[comp_low_pos] = comp_ok && events.comp_low;
   end

   // ****************************************
   // fault register next state
   // ****************************************
   always_comb begin
      fa_next = fa_reg;
      if (wr_fa) begin
         fa_next[user_test_pos] = req.wdata[user_test_pos];
         // write 0 clears, write 1 keeps; supply mux needs the fault gone
         fa_next = fa_next & ~(w0c_mask & ~req.wdata);
         if (!req.wdata[supply_mux_pos] && mux_detect && supply_mux_fault_now) begin
            fa_next[supply_mux_pos] = fa_reg[supply_mux_pos];
         end
      end
      fa_next = fa_next | set_vec;
      fa_next[aux_sum_pos] = |(aux_protect_flags & aux_analog_input);
      fa_next[scan_to_pos] = scan_timeout_flag && !ctrl_reg[scan_to_dis_pos];
      fa_next = fa_next & defined_mask;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fa_reg <= fault_alerts_two_rst;
      end else begin
         fa_reg <= fa_next;
      end
   end

   // ****************************************
   // control, mask and read port
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_reg <= ctrl_rst;
         irq_mask_reg <= mask_rst;
      end else if (req.wr) begin
         if (req.addr == monitor_ctrl_off) begin
            ctrl_reg <= {9'h000, req.wdata[6:0]};
         end
         if (req.addr == irq_mask_off) begin
            irq_mask_reg <= req.wdata & defined_mask;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata <= 16'h0000;
      end else if (req.rd) begin
         unique case (req.addr)
            fault_alerts_two_off: rdata <= fa_reg;
            irq_status_off: rdata <= irq_status_reg;
            irq_mask_off: rdata <= irq_mask_reg;
            monitor_ctrl_off: rdata <= ctrl_reg;
            default: rdata <= 16'h0000;
         endcase
      end else begin
         rdata <= 16'h0000;
      end
   end

   // ****************************************
   // interrupt status: rising bits are sticky
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prev_reg <= 16'h0000;
         irq_status_reg <= 16'h0000;
         irq <= 1'b0;
      end else begin
         prev_reg <= fa_reg;
         // a new rise beats the clear-on-read in the same cycle
         if (req.rd && req.addr == irq_status_off) begin
            irq_status_reg <= fa_reg & ~prev_reg;
         end else begin
            irq_status_reg <= irq_status_reg | (fa_reg & ~prev_reg);
         end
         irq <= |(irq_status_reg & irq_mask_reg);
      end
   end

   // ****************************************
   // outputs and balancing stop
   // ****************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fault_alerts_two <= 16'h0000;
         user_test_alert <= 1'b0;
      end else begin
         fault_alerts_two <= fa_next;
         user_test_alert <= fa_next[user_test_pos];
      end
   end

   // thermal stop stays until the overtemp bit is cleared
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         balance_stop <= 1'b0;
         balance_thermal_stop <= 1'b0;
         balance_activity_state <= balance_idle_code;
      end else if (events.overtemp && balance_active) begin
         balance_stop <= 1'b1;
         balance_thermal_stop <= 1'b1;
         balance_activity_state <= balance_thermal_code;
      end else begin
         balance_stop <= 1'b0;
         if (!fa_reg[overtemp_pos]) begin
            balance_thermal_stop <= 1'b0;
            balance_activity_state <= balance_idle_code;
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   chk_user_bit_write: assert property (@(posedge clk) disable iff (sys_rst)
      wr_fa |=> fa_reg[user_test_pos] == $past(req.wdata[user_test_pos]))
      else $error("user test bit not written");
   chk_mux_gate: assert property (@(posedge clk) disable iff (sys_rst)
      (!fa_reg[supply_mux_pos] && !mux_detect) |=> !fa_reg[supply_mux_pos])
      else $error("supply mux set while gated");
   chk_mux_hold: assert property (@(posedge clk) disable iff (sys_rst)
      (fa_reg[supply_mux_pos] && mux_detect && supply_mux_fault_now) |=>
      fa_reg[supply_mux_pos])
      else $error("supply mux cleared while fault present");
   chk_aux_summary: assert property (@(posedge clk) disable iff (sys_rst)
      ##1 fa_reg[aux_sum_pos] == |($past(aux_protect_flags & aux_analog_input)))
      else $error("aux summary wrong");
   chk_scan_mirror: assert property (@(posedge clk) disable iff (sys_rst)
      ##1 fa_reg[scan_to_pos] == ($past(scan_timeout_flag) &&
      !$past(ctrl_reg[scan_to_dis_pos])))
      else $error("scan timeout mirror wrong");
   chk_overtemp_set: assert property (@(posedge clk) disable iff (sys_rst)
      events.overtemp |=> fa_reg[overtemp_pos])
      else $error("overtemp not latched");
   chk_w1_keeps: assert property (@(posedge clk) disable iff (sys_rst)
      (wr_fa && req.wdata[zero_scale_pos] && fa_reg[zero_scale_pos]) |=>
      fa_reg[zero_scale_pos])
      else $error("write 1 cleared bit");
   chk_event_wins: assert property (@(posedge clk) disable iff (sys_rst)
      (wr_fa && !req.wdata[comp_low_pos] && comp_ok && events.comp_low) |=>
      fa_reg[comp_low_pos])
      else $error("clear beat event");
   chk_thermal_stop: assert property (@(posedge clk) disable iff (sys_rst)
      (events.overtemp && balance_active) |=> balance_stop &&
      balance_activity_state == balance_thermal_code && balance_thermal_stop)
      else $error("balance not stopped");
   chk_unused_zero: assert property (@(posedge clk) disable iff (sys_rst)
      (fa_reg & ~defined_mask) == 16'h0000)
      else $error("unused bits set");
   chk_selftest_gate: assert property (@(posedge clk) disable iff (sys_rst)
      (!ctrl_reg[selftest_en_pos] && !fa_reg[full_scale_pos]) |=>
      !fa_reg[full_scale_pos])
      else $error("full scale set while disabled");

   // ****************************************
   // output, per-bit hold, set and clear checks, then balance stop, interrupt, read and mask checks
   // ****************************************
   chk_user_out: assert property (@(posedge clk) disable iff (sys_rst)
      1'b1 |->
      user_test_alert == fa_reg[user_test_pos])
      else $error("user test output differs");

   chk_user_hold: assert property (@(posedge clk) disable iff (sys_rst)
      !wr_fa |=>
      fa_reg[user_test_pos] == $past(fa_reg[user_test_pos]))
      else $error("user test bit moved without write");

   chk_out_copy: assert property (@(posedge clk) disable iff (sys_rst)
      1'b1 |->
      fault_alerts_two == fa_reg)
      else $error("register copy differs");

   chk_mux_set: assert property (@(posedge clk) disable iff (sys_rst)
      (mux_detect && events.supply_mux) |=>
      fa_reg[supply_mux_pos])
      else $error("supply mux not latched");

   chk_mux_rst_gate: assert property (@(posedge clk) disable iff (sys_rst)
      (reset_alert && !fa_reg[supply_mux_pos]) |=>
      !fa_reg[supply_mux_pos])
      else $error("supply mux set before reset alert cleared");

   chk_mux_w1_keeps: assert property (@(posedge clk) disable iff (sys_rst)
      (wr_fa && req.wdata[supply_mux_pos] && fa_reg[supply_mux_pos]) |=>
      fa_reg[supply_mux_pos])
      else $error("write 1 cleared supply mux");

   chk_mux_clear: assert property (@(posedge clk) disable iff (sys_rst)
      (wr_fa && !req.wdata[supply_mux_pos] && !supply_mux_fault_now &&
      !(mux_detect && events.supply_mux)) |=> !fa_reg[supply_mux_pos])
      else $error("supply mux not cleared");

   chk_mux_keep: assert property (@(posedge clk) disable iff (sys_rst)
      (!wr_fa && fa_reg[supply_mux_pos]) |=>
      fa_reg[supply_mux_pos])
      else $error("supply mux lost");

   chk_aux_no_write: assert property (@(posedge clk) disable iff (sys_rst)
      (wr_fa && (aux_protect_flags & aux_analog_input) != 6'h00) |=>
      fa_reg[aux_sum_pos])
      else $error("aux summary cleared by write");

   chk_aux_clear: assert property (@(posedge clk) disable iff (sys_rst)
      ((aux_protect_flags & aux_analog_input) == 6'h00) |=>
      !fa_reg[aux_sum_pos])
      else $error("aux summary stuck");

   chk_overtemp_keep: assert property (@(posedge clk) disable iff (sys_rst)
      (!wr_fa && fa_reg[overtemp_pos]) |=>
      fa_reg[overtemp_pos])
      else $error("overtemp lost");

   chk_overtemp_w1: assert property (@(posedge clk) disable iff (sys_rst)
      (wr_fa && req.wdata[overtemp_pos] && fa_reg[overtemp_pos]) |=>
      fa_reg[overtemp_pos])
      else $error("write 1 cleared overtemp");

   chk_overtemp_clear: assert property (@(posedge clk) disable iff (sys_rst)
      (wr_fa && !req.wdata[overtemp_pos] && !events.overtemp) |=>
      !fa_reg[overtemp_pos])
      else $error("overtemp not cleared");

   chk_scan_disabled: assert property (@(posedge clk) disable iff (sys_rst)
      ctrl_reg[scan_to_dis_pos] |=>
      !fa_reg[scan_to_pos])
      else $error("scan timeout shown while disabled");

   chk_zero_set: assert property (@(posedge clk) disable iff (sys_rst)
      (ctrl_reg[selftest_en_pos] && events.zero_scale) |=>
      fa_reg[zero_scale_pos])
      else $error("zero scale not latched");

   chk_zero_gate: assert property (@(posedge clk) disable iff (sys_rst)
      (!ctrl_reg[selftest_en_pos] && !fa_reg[zero_scale_pos]) |=>
      !fa_reg[zero_scale_pos])
      else $error("zero scale set while disabled");

   chk_full_set: assert property (@(posedge clk) disable iff (sys_rst)
      (ctrl_reg[selftest_en_pos] && events.full_scale) |=>
      fa_reg[full_scale_pos])
      else $error("full scale not latched");

   chk_high_set: assert property (@(posedge clk) disable iff (sys_rst)
      (comp_ok && events.comp_high) |=>
      fa_reg[comp_high_pos])
      else $error("comparator high not latched");

   chk_high_gate: assert property (@(posedge clk) disable iff (sys_rst)
      (!comp_ok && !fa_reg[comp_high_pos]) |=>
      !fa_reg[comp_high_pos])
      else $error("comparator high set while disabled");

   chk_low_set: assert property (@(posedge clk) disable iff (sys_rst)
      (comp_ok && events.comp_low) |=>
      fa_reg[comp_low_pos])
      else $error("comparator low not latched");

   chk_low_gate: assert property (@(posedge clk) disable iff (sys_rst)
      (!comp_ok && !fa_reg[comp_low_pos]) |=>
      !fa_reg[comp_low_pos])
      else $error("comparator low set while disabled");

   chk_high_clear: assert property (@(posedge clk) disable iff (sys_rst)
      (wr_fa && !req.wdata[comp_high_pos] && !(comp_ok && events.comp_high)) |=>
      !fa_reg[comp_high_pos])
      else $error("comparator high not cleared");

   chk_zero_keep: assert property (@(posedge clk) disable iff (sys_rst)
      (!wr_fa && fa_reg[zero_scale_pos]) |=>
      fa_reg[zero_scale_pos])
      else $error("zero scale lost");

   chk_overtemp_wins: assert property (@(posedge clk) disable iff (sys_rst)
      (wr_fa && events.overtemp) |=>
      fa_reg[overtemp_pos])
      else $error("clear beat overtemp event");

   chk_stop_pulse: assert property (@(posedge clk) disable iff (sys_rst)
      !(events.overtemp && balance_active) |=>
      !balance_stop)
      else $error("balance stop without event");

   chk_stop_state: assert property (@(posedge clk) disable iff (sys_rst)
      balance_thermal_stop |->
      balance_activity_state == balance_thermal_code)
      else $error("thermal stop state code wrong");

   chk_idle_state: assert property (@(posedge clk) disable iff (sys_rst)
      !balance_thermal_stop |->
      balance_activity_state == balance_idle_code)
      else $error("idle state code wrong");

   chk_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
      1'b1 |=>
      irq == |($past(irq_status_reg & irq_mask_reg)))
      else $error("interrupt level wrong");

   chk_irq_sticky: assert property (@(posedge clk) disable iff (sys_rst)
      (irq_status_reg[overtemp_pos] && !(req.rd && req.addr == irq_status_off)) |=>
      irq_status_reg[overtemp_pos])
      else $error("status bit lost without read");

   chk_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst)
      !req.rd |=>
      rdata == 16'h0000)
      else $error("read data without strobe");

   chk_read_value: assert property (@(posedge clk) disable iff (sys_rst)
      (req.rd && req.addr == fault_alerts_two_off) |=>
      rdata == $past(fa_reg))
      else $error("read data wrong");

   chk_mask_unused: assert property (@(posedge clk) disable iff (sys_rst)
      1'b1 |->
      (irq_mask_reg & ~defined_mask) == 16'h0000)
      else $error("unused mask bits set");
endmodule

// ---- tb.sv ----
// testbench for the second fault-alert register bank
// assumes fault_alert_pkg and fault_alert_register_two are compiled first
`timescale 1ns/100ps
module tb;
   import fault_alert_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   reg_req_s req = '0;
   fault_events_s events = '0;
   logic supply_mux_fault_now = 1'b0, reset_alert = 1'b0;
   logic scan_timeout_flag = 1'b0, balance_active = 1'b0;
   logic [5:0] aux_protect_flags = '0, aux_analog_input = '0;
   logic [15:0] rdata, fault_alerts_two, v;
   logic user_test_alert, balance_stop, balance_thermal_stop, irq;
   logic [1:0] balance_activity_state;
   int errors = 0, num_checks = 0;
   always #20 clk = ~clk;
   fault_alert_register_two DUT (.clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata),
      .events(events), .supply_mux_fault_now(supply_mux_fault_now),
      .reset_alert(reset_alert), .aux_protect_flags(aux_protect_flags),
      .aux_analog_input(aux_analog_input), .scan_timeout_flag(scan_timeout_flag),
      .balance_active(balance_active), .fault_alerts_two(fault_alerts_two),
      .user_test_alert(user_test_alert), .balance_stop(balance_stop),
      .balance_thermal_stop(balance_thermal_stop),
      .balance_activity_state(balance_activity_state), .irq(irq));
   // ****************************************
   // bus and compare helpers
   // ****************************************
   task chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge clk);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task rchk(input logic [3:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      chk(d, exp);
   endtask
   task pulse(input logic [5:0] e);
      @(posedge clk);
      events <= fault_events_s'(e);
      @(posedge clk);
      events <= '0;
   endtask
   task wait_settle;
      repeat (3) @(posedge clk);
      #1;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task t_reset;
      chk(fault_alerts_two, 16'h0000);
      rchk(fault_alerts_two_off, fault_alerts_two_rst);
      rchk(irq_mask_off, mask_rst);
      rchk(monitor_ctrl_off, ctrl_rst);
      rchk(4'hF, 16'h0000);
   endtask
   task t_user;
      wr(fault_alerts_two_off, 16'hFFFF);
      rchk(fault_alerts_two_off, 16'h8000);
      chk(user_test_alert, 1'b1);
      wr(fault_alerts_two_off, 16'h0000);
      rchk(fault_alerts_two_off, 16'h0000);
   endtask
   task t_events;
      wr(monitor_ctrl_off, 16'h0017);
      balance_active <= 1'b1;
      supply_mux_fault_now <= 1'b1;
      pulse(6'h3F);
      #1 chk(balance_stop, 1'b1);
      chk(fault_alerts_two, 16'h500F);
      @(posedge clk);
      #1 chk(balance_stop, 1'b0);
      rchk(fault_alerts_two_off, 16'h500F);
      chk(balance_thermal_stop, 1'b1);
      chk(balance_activity_state, 2'h3);
      wr(fault_alerts_two_off, 16'h7FFF);
      rchk(fault_alerts_two_off, 16'h500F);
      wr(fault_alerts_two_off, 16'h0000);
      rchk(fault_alerts_two_off, 16'h4000);
      supply_mux_fault_now <= 1'b0;
      wr(fault_alerts_two_off, 16'h0000);
      rchk(fault_alerts_two_off, 16'h0000);
      chk(balance_thermal_stop, 1'b0);
      balance_active <= 1'b0;
   endtask
   // disabled qualifiers must swallow the events
   task t_qual;
      reset_alert <= 1'b1;
      wr(monitor_ctrl_off, 16'h0037);
      pulse(6'h23);
      rchk(fault_alerts_two_off, 16'h0000);
      reset_alert <= 1'b0;
      wr(monitor_ctrl_off, 16'h0024);
      pulse(6'h2F);
      rchk(fault_alerts_two_off, 16'h0003);
      wr(fault_alerts_two_off, 16'h0000);
      wr(monitor_ctrl_off, 16'h0010);
      pulse(6'h03);
      rchk(fault_alerts_two_off, 16'h0000);
   endtask
   task t_aux;
      aux_protect_flags <= 6'h05;
      aux_analog_input <= 6'h02;
      rchk(fault_alerts_two_off, 16'h0000);
      aux_analog_input <= 6'h04;
      rchk(fault_alerts_two_off, 16'h2000);
      wr(fault_alerts_two_off, 16'h0000);
      rchk(fault_alerts_two_off, 16'h2000);
      aux_protect_flags <= 6'h00;
      rchk(fault_alerts_two_off, 16'h0000);
   endtask
   task t_scan;
      scan_timeout_flag <= 1'b1;
      rchk(fault_alerts_two_off, 16'h0800);
      wr(fault_alerts_two_off, 16'h0000);
      rchk(fault_alerts_two_off, 16'h0800);
      wr(monitor_ctrl_off, 16'h0008);
      rchk(fault_alerts_two_off, 16'h0000);
      scan_timeout_flag <= 1'b0;
      wr(monitor_ctrl_off, 16'h0000);
   endtask
   // clear and new event on the same edge
   task t_clash;
      @(posedge clk);
      req.addr <= fault_alerts_two_off;
      req.wdata <= 16'h0000;
      req.wr <= 1'b1;
      events <= fault_events_s'(6'h10);
      @(posedge clk);
      req.wr <= 1'b0;
      events <= '0;
      rchk(fault_alerts_two_off, 16'h1000);
      wr(fault_alerts_two_off, 16'h0000);
   endtask
   task t_irq;
      rd(irq_status_off, v);
      pulse(6'h10);
      wait_settle;
      chk(irq, 1'b0);
      wr(irq_mask_off, 16'h1000);
      wait_settle;
      chk(irq, 1'b1);
      rchk(irq_status_off, 16'h1000);
      wait_settle;
      chk(irq, 1'b0);
      rchk(irq_status_off, 16'h0000);
      wr(fault_alerts_two_off, 16'h0000);
   endtask
   task summarize;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ****************************************
   // main sequence and watchdog
   // ****************************************
   initial begin
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset;
      t_user;
      t_events;
      t_qual;
      t_aux;
      t_scan;
      t_clash;
      t_irq;
      summarize;
   end
   // the sequence needs about a hundred cycles; a hang stops well past that
   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      summarize;
   end
endmodule
